//--- core/pwr_sup_pkg.sv
// Constants shared by the logger power supervisor.
// Assumes a single 40 MHz system clock and a plain register port.
package pwr_sup_pkg;
    // System clock
    localparam int CLK_HZ        = 40_000_000;
    localparam int MS_PER_S      = 1000;
    // Clock cycles in one millisecond tick
    localparam int CYC_PER_MS    = CLK_HZ / MS_PER_S;
    // Intervals in their printed units
    localparam int DEBOUNCE_MS   = 1000;
    localparam int PG_WAIT_MIN   = 3;
    localparam int WDOG_MIN      = 2;
    localparam int EMERG_MIN     = 60;
    localparam int MS_PER_MIN    = 60_000;
    // Intervals in millisecond ticks
    localparam int PG_WAIT_TICKS = PG_WAIT_MIN * MS_PER_MIN;
    localparam int WDOG_TICKS    = WDOG_MIN * MS_PER_MIN;
    localparam int EMERG_TICKS   = EMERG_MIN * MS_PER_MIN;
    // Register offsets (byte addresses)
    localparam logic [7:0] CTRL_OFS  = 8'h00;
    localparam logic [7:0] STAT_OFS  = 8'h04;
    localparam logic [7:0] IRQS_OFS  = 8'h08;
    localparam logic [7:0] IRQM_OFS  = 8'h0C;
    localparam logic [7:0] KICK_OFS  = 8'h10;
    // Control fields
    localparam int CTRL_WDOG_ON  = 0;
    // Status fields
    localparam int ST_PWR_ON     = 0;
    localparam int ST_PGOOD      = 1;
    localparam int ST_PBAD       = 2;
    localparam int ST_WDOG       = 3;
    localparam int ST_SHUTDN     = 4;
    localparam int ST_REMOTE     = 5;
    localparam int ST_WR_EN      = 6;
    // Event bits, same layout in status and mask
    localparam int EV_ON         = 0;
    localparam int EV_PGOOD      = 1;
    localparam int EV_PG_TMO     = 2;
    localparam int EV_WDOG_TMO   = 3;
    localparam int EV_SHUTDN     = 4;
    localparam int EV_EMERG      = 5;
    localparam int EV_PBAD       = 6;
    localparam int EV_W          = 7;
    // Reset values
    localparam logic [EV_W-1:0] IRQM_RST = 7'h00;
    // Supervisor states
    typedef enum logic [1:0] {
        ST_OFF,
        ST_WAIT_PG,
        ST_RUN,
        ST_SHUTDOWN
    } sup_state_t;
endpackage

//--- core/logger_power_supervisor.sv
// Power supervisor for a data logger: remote wake debounce, storage
// write gating on power good, watchdog and shutdown deadlines.
// Assumes all inputs synchronous to CLK_SYS_I and one register master.
`timescale 1ns/1ps
module logger_power_supervisor #(
    parameter int CYC_MS   = pwr_sup_pkg::CYC_PER_MS,
    parameter int DEB_MS   = pwr_sup_pkg::DEBOUNCE_MS,
    parameter int PG_MS    = pwr_sup_pkg::PG_WAIT_TICKS,
    parameter int WDOG_MS  = pwr_sup_pkg::WDOG_TICKS,
    parameter int EMERG_MS = pwr_sup_pkg::EMERG_TICKS
) (
    // Clock and reset
    input  wire logic        CLK_SYS_I,
    input  wire logic        RSTN_I,
    // Supply monitoring
    input  wire logic        REMOTE_WAKE_I,
    input  wire logic        HOLD_UP_CAPACITORS_CHARGED_I,
    input  wire logic        EXC_LOW_I,
    // Register port
    input  wire logic [7:0]  ADDR_I,
    input  wire logic [31:0] WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [31:0] RDATA_O,
    // Power control and status
    output logic             POWER_EN_O,
    output logic             WRITE_EN_O,
    output logic             POWER_GOOD_O,
    output logic             POWER_BAD_O,
    output logic             HOST_CTRL_O,
    output logic             SHUTDOWN_O,
    output logic             IRQ_O
);

    // Counter reached its limit on this tick
    function automatic logic reached(input logic [31:0] cnt,
                                     input int lim);
        reached = (cnt >= 32'(lim));
    endfunction

    // Millisecond tick
    logic [31:0] pre_cnt;      // Clock cycles within the current ms
    wire         ms_tick = reached(pre_cnt, CYC_MS - 1);

    // Free prescaler; every interval below counts these ticks
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pre_cnt <= 32'h0;
        end else if (ms_tick) begin
            pre_cnt <= 32'h0;
        end else begin
            pre_cnt <= pre_cnt + 32'h1;
        end
    end

    // Remote wake debounce
    logic        remote_deb;   // Debounced remote level
    logic [31:0] deb_cnt;      // Ms the raw level has differed
    wire         deb_diff = REMOTE_WAKE_I != remote_deb;
    // Needs DEB_MS+1 ticks because the first tick may land at once,
    // so the level has held for more than DEB_MS whole milliseconds
    wire         deb_done = deb_diff && ms_tick &&
                            reached(deb_cnt, DEB_MS);
    // Only a freshly accepted rise wakes; a level still high after a
    // timeout must not power the logger straight back on
    wire         wake_accept = deb_done && REMOTE_WAKE_I;

    // Both edges debounced; any blip resets the count
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            deb_cnt    <= 32'h0;
            remote_deb <= 1'b0;
        end else if (!deb_diff) begin
            deb_cnt <= 32'h0;
        end else if (deb_done) begin
            deb_cnt    <= 32'h0;
            remote_deb <= REMOTE_WAKE_I;
        end else if (ms_tick) begin
            deb_cnt <= deb_cnt + 32'h1;
        end
    end

    // Main sequence
    pwr_sup_pkg::sup_state_t state;       // Current state
    pwr_sup_pkg::sup_state_t next_state;  // Next state
    logic [31:0] st_cnt;       // Ms spent in current state
    logic [31:0] wd_cnt;       // Ms since last kick toggle
    logic        wdog_on;      // Host owns operation
    logic        kick_bit;     // Last written kick bit
    logic        pgood;        // Registered capacitor charge state
    logic        pbad;         // Registered excitation low flag

    // Register decode
    wire sel_ctrl = ADDR_I == pwr_sup_pkg::CTRL_OFS;
    wire sel_stat = ADDR_I == pwr_sup_pkg::STAT_OFS;
    wire sel_irqs = ADDR_I == pwr_sup_pkg::IRQS_OFS;
    wire sel_irqm = ADDR_I == pwr_sup_pkg::IRQM_OFS;
    wire sel_kick = ADDR_I == pwr_sup_pkg::KICK_OFS;
    wire powered  = state != pwr_sup_pkg::ST_OFF;

    // Host may only take over while the logger is powered, in any state but ST_OFF
    wire wd_arm   = WR_I && sel_ctrl && powered &&
                    WDATA_I[pwr_sup_pkg::CTRL_WDOG_ON];
    wire kicked   = WR_I && sel_kick && (WDATA_I[0] != kick_bit);

    // Timeouts
    wire pg_tmo   = state == pwr_sup_pkg::ST_WAIT_PG && ms_tick &&
                    reached(st_cnt, PG_MS - 1);
    wire em_tmo   = state == pwr_sup_pkg::ST_SHUTDOWN && ms_tick &&
                    reached(st_cnt, EMERG_MS - 1);
    // Trips one tick past the limit, so strictly longer than it
    wire wd_tmo   = wdog_on && powered && !kicked && ms_tick &&
                    reached(wd_cnt, WDOG_MS);

    // Next state
    always_comb begin
        next_state = state;
        case (state)
            pwr_sup_pkg::ST_OFF: begin
                if (wake_accept) begin
                    next_state = pwr_sup_pkg::ST_WAIT_PG;
                end
            end
            pwr_sup_pkg::ST_WAIT_PG: begin
                if (pg_tmo) begin
                    next_state = pwr_sup_pkg::ST_OFF;
                end else if (pgood) begin
                    next_state = pwr_sup_pkg::ST_RUN;
                end else if (!remote_deb) begin
                    next_state = pwr_sup_pkg::ST_SHUTDOWN;
                end
            end
            pwr_sup_pkg::ST_RUN: begin
                if (!remote_deb) begin
                    next_state = pwr_sup_pkg::ST_SHUTDOWN;
                end
            end
            pwr_sup_pkg::ST_SHUTDOWN: begin
                if (em_tmo) begin
                    next_state = pwr_sup_pkg::ST_OFF;
                end
            end
            default: begin
                next_state = pwr_sup_pkg::ST_OFF;
            end
        endcase
        // Watchdog expiry overrides every other path
        if (wd_tmo) begin
            next_state = pwr_sup_pkg::ST_OFF;
        end
    end

    // State register and state timer
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state  <= pwr_sup_pkg::ST_OFF;
            st_cnt <= 32'h0;
        end else begin
            state <= next_state;
            if (next_state != state) begin
                st_cnt <= 32'h0;
            end else if (ms_tick) begin
                st_cnt <= st_cnt + 32'h1;
            end
        end
    end

    // Watchdog: armed by software, dropped only when power goes off
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            wdog_on  <= 1'b0;
            wd_cnt   <= 32'h0;
            kick_bit <= 1'b0;
        end else if (next_state == pwr_sup_pkg::ST_OFF) begin
            wdog_on <= 1'b0;
            wd_cnt  <= 32'h0;
        end else begin
            if (wd_arm) begin
                wdog_on <= 1'b1;
            end
            if (WR_I && sel_kick) begin
                kick_bit <= WDATA_I[0];
            end
            // Only a change of the bit proves the host alive
            if (kicked || !wdog_on) begin
                wd_cnt <= 32'h0;
            end else if (ms_tick) begin
                wd_cnt <= wd_cnt + 32'h1;
            end
        end
    end

    // Supply flags; power bad ignores capacitor charge entirely
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pgood <= 1'b0;
            pbad  <= 1'b0;
        end else begin
            pgood <= powered && HOLD_UP_CAPACITORS_CHARGED_I;
            pbad  <= EXC_LOW_I;
        end
    end

    // Interrupt events, one cycle each
    logic [pwr_sup_pkg::EV_W-1:0] irq_stat;   // Sticky events
    logic [pwr_sup_pkg::EV_W-1:0] irq_mask;   // Enable per event
    logic [pwr_sup_pkg::EV_W-1:0] events;     // This cycle's events
    wire entering = next_state != state;
    always_comb begin
        events = '0;
        events[pwr_sup_pkg::EV_ON]       = entering &&
            next_state == pwr_sup_pkg::ST_WAIT_PG;
        events[pwr_sup_pkg::EV_PGOOD]    = entering &&
            next_state == pwr_sup_pkg::ST_RUN;
        events[pwr_sup_pkg::EV_PG_TMO]   = pg_tmo;
        events[pwr_sup_pkg::EV_WDOG_TMO] = wd_tmo;
        events[pwr_sup_pkg::EV_SHUTDN]   = entering &&
            next_state == pwr_sup_pkg::ST_SHUTDOWN;
        events[pwr_sup_pkg::EV_EMERG]    = em_tmo;
        events[pwr_sup_pkg::EV_PBAD]     = EXC_LOW_I && !pbad;
    end

    // Write-one-to-clear; a new event in the same cycle wins
    wire [pwr_sup_pkg::EV_W-1:0] irq_clr =
        (WR_I && sel_irqs) ? WDATA_I[pwr_sup_pkg::EV_W-1:0] : '0;

    // Interrupt status and mask registers
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            irq_stat <= '0;
            irq_mask <= pwr_sup_pkg::IRQM_RST;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | events;
            if (WR_I && sel_irqm) begin
                irq_mask <= WDATA_I[pwr_sup_pkg::EV_W-1:0];
            end
        end
    end

    // Write gate: storage only while the capacitors can hold up
    wire wr_gate = pgood && (state == pwr_sup_pkg::ST_RUN ||
                   state == pwr_sup_pkg::ST_SHUTDOWN);

    // Status word
    logic [31:0] stat_word;
    always_comb begin
        stat_word = 32'h0;
        stat_word[pwr_sup_pkg::ST_PWR_ON] = powered;
        stat_word[pwr_sup_pkg::ST_PGOOD]  = pgood;
        stat_word[pwr_sup_pkg::ST_PBAD]   = pbad;
        stat_word[pwr_sup_pkg::ST_WDOG]   = wdog_on;
        stat_word[pwr_sup_pkg::ST_SHUTDN] =
            state == pwr_sup_pkg::ST_SHUTDOWN;
        stat_word[pwr_sup_pkg::ST_REMOTE] = remote_deb;
        stat_word[pwr_sup_pkg::ST_WR_EN]  = wr_gate;
    end

    // Read mux; unmapped addresses read zero
    wire [31:0] rd_mux =
        sel_ctrl ? {31'h0, wdog_on} :
        sel_stat ? stat_word :
        sel_irqs ? {25'h0, irq_stat} :
        sel_irqm ? {25'h0, irq_mask} :
        sel_kick ? {31'h0, kick_bit} : 32'h0;

    // Read data lasts exactly the cycle after the strobe
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            RDATA_O <= 32'h0;
        end else begin
            RDATA_O <= RD_I ? rd_mux : 32'h0;
        end
    end

    // Outputs, all from flip-flops
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            POWER_EN_O   <= 1'b0;
            WRITE_EN_O   <= 1'b0;
            POWER_GOOD_O <= 1'b0;
            POWER_BAD_O  <= 1'b0;
            HOST_CTRL_O  <= 1'b0;
            SHUTDOWN_O   <= 1'b0;
            IRQ_O        <= 1'b0;
        end else begin
            POWER_EN_O   <= powered;
            WRITE_EN_O   <= wr_gate;
            POWER_GOOD_O <= pgood;
            POWER_BAD_O  <= pbad;
            HOST_CTRL_O  <= wdog_on;
            SHUTDOWN_O   <= state == pwr_sup_pkg::ST_SHUTDOWN;
            IRQ_O        <= |(irq_stat & irq_mask);
        end
    end

endmodule // logger_power_supervisor

//--- tb/pwr_sup_properties.sv
// Port checks for the logger power supervisor, bound from the bench.
// Assumes the interval parameters match the watched instance.
`timescale 1ns/1ps
module pwr_sup_properties #(
    parameter int CYC_MS   = 4,
    parameter int DEB_MS   = 3,
    parameter int PG_MS    = 20,
    parameter int WDOG_MS  = 10,
    parameter int EMERG_MS = 30
) (
    // Watched ports
    input wire logic        CLK_SYS_I,
    input wire logic        RSTN_I,
    input wire logic        REMOTE_WAKE_I,
    input wire logic        HOLD_UP_CAPACITORS_CHARGED_I,
    input wire logic        EXC_LOW_I,
    input wire logic [7:0]  ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic        WR_I,
    input wire logic        RD_I,
    input wire logic [31:0] RDATA_O,
    input wire logic        POWER_EN_O,
    input wire logic        WRITE_EN_O,
    input wire logic        POWER_GOOD_O,
    input wire logic        POWER_BAD_O,
    input wire logic        HOST_CTRL_O,
    input wire logic        SHUTDOWN_O,
    input wire logic        IRQ_O
);
    // Bounds carry tick slack: timers only move on millisecond ticks
    int   rem_cnt;  // Cycles remote held high
    int   pg_cnt;   // Cycles powered without power good
    int   wd_cnt;   // Cycles under watchdog since last toggle
    int   sd_cnt;   // Cycles in shutdown
    logic kick;     // Last kick bit seen on the bus
    logic toggled;  // Kick write with an inverted bit
    assign toggled = WR_I && ADDR_I == pwr_sup_pkg::KICK_OFS
                     && WDATA_I[0] != kick;
    // Counters for the long intervals
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rem_cnt <= 0;
            pg_cnt  <= 0;
            wd_cnt  <= 0;
            sd_cnt  <= 0;
            kick    <= 1'b0;
        end else begin
            rem_cnt <= REMOTE_WAKE_I ? rem_cnt + 1 : 0;
            pg_cnt  <= (POWER_EN_O && !POWER_GOOD_O && !SHUTDOWN_O)
                       ? pg_cnt + 1 : 0;
            wd_cnt  <= (HOST_CTRL_O && !toggled) ? wd_cnt + 1 : 0;
            sd_cnt  <= SHUTDOWN_O ? sd_cnt + 1 : 0;
            kick    <= toggled ? WDATA_I[0] : kick;
        end
    end
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!RSTN_I);
    property p_debounce; $rose(POWER_EN_O) |-> rem_cnt >= DEB_MS*CYC_MS; endproperty
    a_debounce: assert property (p_debounce) else $error("power on too early");
    property p_wr_gate; $rose(WRITE_EN_O) |-> POWER_GOOD_O && POWER_EN_O; endproperty
    a_wr_gate: assert property (p_wr_gate) else $error("write enable early");
    property p_pgood; POWER_EN_O && $rose(HOLD_UP_CAPACITORS_CHARGED_I) |-> ##[1:2] POWER_GOOD_O; endproperty
    a_pgood: assert property (p_pgood) else $error("power good missing");
    property p_pg_lim; pg_cnt <= (PG_MS + 2) * CYC_MS + 2; endproperty
    a_pg_lim: assert property (p_pg_lim) else $error("no power good timeout");
    property p_host; $rose(HOST_CTRL_O) |-> POWER_EN_O; endproperty
    a_host: assert property (p_host) else $error("host control while off");
    property p_wdog; wd_cnt <= (WDOG_MS + 3) * CYC_MS; endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog did not expire");
    property p_pbad; POWER_BAD_O == $past(EXC_LOW_I, 2); endproperty
    a_pbad: assert property (p_pbad) else $error("power bad wrong");
    property p_emerg; sd_cnt <= (EMERG_MS + 2) * CYC_MS; endproperty
    a_emerg: assert property (p_emerg) else $error("shutdown overran");
    property p_rd_idle; !$past(RD_I) |-> RDATA_O == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
endmodule // pwr_sup_properties

//--- tb/host_model.sv
// Acquisition host: inverts the watchdog kick bit while running.
// Assumes the bench keeps the register port idle meanwhile.
`timescale 1ns/1ps
module host_model #(
    parameter int PERIOD = 16  // Cycles between kicks
) (
    // Control
    input  wire logic        clk_i,
    input  wire logic        run_i,
    // Register port requests
    output logic             wr_o,
    output logic [7:0]       addr_o,
    output logic [31:0]      wdata_o
);
    int   cnt = 0;        // Cycles since last kick
    logic bit_q = 1'b0;   // Bit sent last
    initial wr_o = 1'b0;
    initial addr_o = 8'h00;
    initial wdata_o = 32'h0;
    // Dropping run models the host ending post-processing
    always @(posedge clk_i) begin
        if (run_i && cnt >= PERIOD) begin  // Each write inverts
            cnt     <= 0;
            bit_q   <= !bit_q;
            wr_o    <= 1'b1;
            addr_o  <= pwr_sup_pkg::KICK_OFS;
            wdata_o <= {31'h0, !bit_q};
        end else begin  // Released lines toggle, never hold
            cnt     <= cnt + 1;
            wr_o    <= 1'b0;
            addr_o  <= ~addr_o;
            wdata_o <= ~wdata_o;
        end
    end
endmodule // host_model

//--- tb/logger_power_supervisor_bench.sv
// Bench for the logger power supervisor with a host model.
// Assumes shortened intervals: 4 cycles per millisecond tick.
`timescale 1ns/1ps
module logger_power_supervisor_bench;
    localparam int CM = 4;   // Cycles per tick
    localparam int DM = 3;   // Debounce ticks
    localparam int PM = 20;  // Power good wait ticks
    localparam int WM = 10;  // Watchdog ticks
    localparam int EM = 30;  // Emergency ticks
    logic        clk, rstn, remote_wake_input, hold_up_capacitors, exc, wr_b, rd, run, wr, p_wr;
    logic        pwr, wen, pg, pb, host, sd, irq;
    logic [7:0]  addr_b, addr, p_addr;
    logic [31:0] wdata_b, wdata, p_wdata, rdata;
    int          n_fail = 0, check_count = 0, cyc = 0, n, t0;
    // Host owns the port only while it strobes
    assign wr = wr_b | p_wr;
    assign addr = p_wr ? p_addr : addr_b;
    assign wdata = p_wr ? p_wdata : wdata_b;
    logger_power_supervisor #(.CYC_MS(CM), .DEB_MS(DM), .PG_MS(PM),
        .WDOG_MS(WM), .EMERG_MS(EM)) dut_u (.CLK_SYS_I(clk),
        .RSTN_I(rstn), .REMOTE_WAKE_I(remote_wake_input), .HOLD_UP_CAPACITORS_CHARGED_I(hold_up_capacitors),
        .EXC_LOW_I(exc), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .POWER_EN_O(pwr), .WRITE_EN_O(wen),
        .POWER_GOOD_O(pg), .POWER_BAD_O(pb), .HOST_CTRL_O(host),
        .SHUTDOWN_O(sd), .IRQ_O(irq));
    host_model #(.PERIOD(4 * CM)) host_u (.clk_i(clk), .run_i(run),
        .wr_o(p_wr), .addr_o(p_addr), .wdata_o(p_wdata));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Hang guard, far above the expected run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            end_sim();
        end
    end
    function automatic logic [31:0] bv(input int b);
        return 32'h1 << b;
    endfunction
    task automatic ck(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) {wr_b, addr_b, wdata_b} <= {1'b1, a, d};
        @(posedge clk) wr_b <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk) {rd, addr_b} <= {1'b1, a};
        @(posedge clk) rd <= 1'b0;
        #1 ck(rdata, e);
    endtask
    task automatic pause(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // Bounded wait for the power output
    task automatic wait_pwr(input logic v);
        for (n = 0; pwr !== v && n < 2000; n++) begin
            @(posedge clk);
            #1;
        end
        ck(pwr, v);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        {rstn, remote_wake_input, hold_up_capacitors, exc, wr_b, rd, run} = 7'h00;
        {addr_b, wdata_b} = 40'h0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        rd_reg(pwr_sup_pkg::STAT_OFS, 32'h0);
        rd_reg(pwr_sup_pkg::IRQM_OFS, 32'h0);
        rd_reg(8'h14, 32'h0);
        $display("reset test done");
        @(posedge clk) remote_wake_input <= 1'b1;
        pause((DM - 2) * CM);
        @(posedge clk) remote_wake_input <= 1'b0;
        pause(2 * DM * CM);
        ck(pwr, 1'b0);
        wr_reg(pwr_sup_pkg::IRQM_OFS, 32'h7F);
        @(posedge clk) remote_wake_input <= 1'b1;
        wait_pwr(1'b1);
        t0 = cyc;
        ck(n >= DM * CM && n <= (DM + 1) * CM + 2, 1'b1);
        ck(irq, 1'b1);
        wr_reg(pwr_sup_pkg::IRQS_OFS, bv(pwr_sup_pkg::EV_ON));
        pause(2);
        ck({irq, wen}, 2'b00);
        @(posedge clk) exc <= 1'b1;
        pause(3);
        ck({pb, pg}, 2'b10);
        @(posedge clk) exc <= 1'b0;
        wr_reg(pwr_sup_pkg::IRQM_OFS, 32'h0);
        pause(2);
        ck(irq, 1'b0);
        wait_pwr(1'b0);
        ck(cyc - t0 >= (PM - 1) * CM && cyc - t0 <= (PM + 2) * CM, 1);
        @(posedge clk) remote_wake_input <= 1'b0;
        rd_reg(pwr_sup_pkg::IRQS_OFS, bv(pwr_sup_pkg::EV_PBAD)
            | bv(pwr_sup_pkg::EV_PG_TMO));
        pause(2 * DM * CM);
        wait_pwr(1'b0);
        wr_reg(pwr_sup_pkg::IRQS_OFS, 32'h7F);
        $display("wake and timeout test done");
        @(posedge clk) remote_wake_input <= 1'b1;
        wait_pwr(1'b1);
        @(posedge clk) hold_up_capacitors <= 1'b1;
        pause(4);
        ck(wen, 1'b1);
        wr_reg(pwr_sup_pkg::CTRL_OFS, 32'h1);
        rd_reg(pwr_sup_pkg::STAT_OFS, 32'h6B);
        ck(host, 1'b1);
        @(posedge clk) run <= 1'b1;
        pause(3 * WM * CM);
        ck(pwr, 1'b1);
        @(posedge clk) run <= 1'b0;
        t0 = cyc;
        wait_pwr(1'b0);
        ck(cyc - t0 >= (WM - 4) * CM && cyc - t0 <= (WM + 3) * CM, 1);
        @(posedge clk) remote_wake_input <= 1'b0;
        rd_reg(pwr_sup_pkg::IRQS_OFS, 32'h0B);
        pause(2 * DM * CM);
        wait_pwr(1'b0);
        wr_reg(pwr_sup_pkg::IRQS_OFS, 32'h7F);
        $display("watchdog test done");
        @(posedge clk) remote_wake_input <= 1'b1;
        wait_pwr(1'b1);
        wr_reg(pwr_sup_pkg::CTRL_OFS, 32'h1);
        @(posedge clk) run <= 1'b1;
        @(posedge clk) remote_wake_input <= 1'b0;
        t0 = cyc;
        pause((DM + 2) * CM);
        ck(sd, 1'b1);
        wait_pwr(1'b0);
        ck(cyc - t0 >= (EM + DM) * CM &&
           cyc - t0 <= (EM + DM + 2) * CM, 1);
        @(posedge clk) run <= 1'b0;
        rd_reg(pwr_sup_pkg::IRQS_OFS, 32'h33);
        $display("shutdown test done");
        end_sim();
    end
endmodule // logger_power_supervisor_bench
bind logger_power_supervisor pwr_sup_properties #(.CYC_MS(CYC_MS),
    .DEB_MS(DEB_MS), .PG_MS(PG_MS), .WDOG_MS(WDOG_MS),
    .EMERG_MS(EMERG_MS)) chk_u (.CLK_SYS_I, .RSTN_I, .REMOTE_WAKE_I,
    .HOLD_UP_CAPACITORS_CHARGED_I, .EXC_LOW_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I,
    .RDATA_O, .POWER_EN_O, .WRITE_EN_O, .POWER_GOOD_O, .POWER_BAD_O,
    .HOST_CTRL_O, .SHUTDOWN_O, .IRQ_O);
